// [shared/fpa_cfg.svh]
// timing counts and layout constants for the front panel annunciator
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH
`define FPA_CLK_HZ 20000000
`define FPA_BEEP_PERIOD_MS 500
`define FPA_BEEP_HALF_CYC ((`FPA_CLK_HZ / 1000) * `FPA_BEEP_PERIOD_MS / 2)
`define FPA_FLASH_HALF_CYC ((`FPA_CLK_HZ / 1000) * 250)
`define FPA_BLANK_MIN 30
`define FPA_BLANK_SEC (`FPA_BLANK_MIN * 60)
`define FPA_SCROLL_SEC 3
`define FPA_SEC_CYC `FPA_CLK_HZ
`define FPA_NUM_KEYS 5
`define FPA_NUM_ITEMS 8
`endif

// [shared/fpa_pkg.sv]
// types for the front panel annunciator
package fpa_pkg;
  // operating mode of the power system
  typedef enum logic [1:0] {MODE_OFF, MODE_ONLINE, MODE_BATTERY, MODE_BYPASS} fpa_mode_t;
  // screen shown on the display
  typedef enum logic [2:0] {SCR_SPLASH, SCR_MIMIC, SCR_EVENTS, SCR_METERS, SCR_CONTROLS,
    SCR_SETUP} fpa_screen_t;
  // status line items
  typedef enum logic [2:0] {ITM_MODEL, ITM_DATE, ITM_ALARMS, ITM_NOTICES, ITM_LOAD,
    ITM_RUNTIME, ITM_TEMP, ITM_HUMID} fpa_item_t;
  // event message categories
  typedef enum logic [1:0] {CAT_ALARM, CAT_NOTICE, CAT_STATUS, CAT_COMMAND} fpa_cat_t;
  // lamp outputs
  typedef struct packed {
    logic online;
    logic battery;
    logic bypass;
    logic alarm;
  } fpa_lamps_t;
  // one event message
  typedef struct packed {
    logic valid;
    fpa_cat_t cat;
    logic [7:0] code;
    logic to_history;
  } fpa_event_t;
  // key function label per navigation key
  typedef enum logic [2:0] {LBL_NONE, LBL_EVENTS, LBL_METERS, LBL_CONTROLS, LBL_SETUP,
    LBL_LOADOFF, LBL_HOME} fpa_label_t;
endpackage : fpa_pkg

// [design/fpa_key_sync.sv]
// pushbutton synchroniser and single any-key pulse
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module fpa_key_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`FPA_NUM_KEYS-1:0] keys_in,
  output logic [`FPA_NUM_KEYS-1:0] key_press,
  output logic any_press
);
  // ----------------------------------------
  // two-stage synchroniser, then edge detect
  // ----------------------------------------
  logic [`FPA_NUM_KEYS-1:0] s1_reg, s2_reg, s3_reg; // sync chain and last level
  logic [`FPA_NUM_KEYS-1:0] s1_next, s2_next, s3_next, press_next;
  logic any_next;
  // next values; only s2 and s3 feed logic, s1 is left alone
  always_comb begin
    s1_next = keys_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    press_next = s2_reg & ~s3_reg;
    any_next = |(s2_reg & ~s3_reg);
  end
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      key_press <= '0;
      any_press <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      key_press <= press_next;
      any_press <= any_next;
    end
  end
  // one pulse per press, never two in a row
  a_any_single: assert property (@(posedge clk) disable iff (reset)
    any_press |=> !any_press) else $error("any-key pulse longer than one cycle");
endmodule : fpa_key_sync

// [design/fpa_annunciator.sv]
// front panel annunciator: lamps, horn, display blanking, screens, status scroll
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module fpa_annunciator #(
  // timebases default to the real timings; a short run may pass smaller ones
  parameter logic [24:0] BEEP_HALF = 25'(`FPA_BEEP_HALF_CYC), // clocks per horn half period
  parameter logic [24:0] FLASH_HALF = 25'(`FPA_FLASH_HALF_CYC), // clocks per flash half period
  parameter logic [24:0] SEC_CYC = 25'(`FPA_SEC_CYC), // clocks per second
  parameter logic [11:0] BLANK_SEC = 12'(`FPA_BLANK_SEC) // idle seconds before darkening
) (
  input wire logic clk,
  input wire logic reset,
  input wire fpa_pkg::fpa_mode_t mode, // present operating mode
  input wire logic alarm_active, // any alarm present
  input wire logic notice_attn, // a notice needs attention
  input wire logic probe_fitted, // environmental probe installed
  input wire logic [`FPA_NUM_KEYS-1:0] keys_in, // raw pushbuttons, asynchronous
  input wire fpa_pkg::fpa_event_t event_in, // event message, one-cycle valid
  output fpa_pkg::fpa_lamps_t lamps,
  output logic horn,
  output logic display_on,
  output fpa_pkg::fpa_screen_t screen,
  output fpa_pkg::fpa_item_t status_item,
  output logic top_line_on,
  output fpa_pkg::fpa_event_t status_msg,
  output logic active_log_wr,
  output logic history_log_wr,
  output logic [7:0] log_code,
  output fpa_pkg::fpa_cat_t log_cat,
  output logic list_alarms,
  output logic list_notices,
  output logic list_commands,
  output fpa_pkg::fpa_label_t [`FPA_NUM_KEYS-1:0] key_labels
);
  // ----------------------------------------
  // keys
  // ----------------------------------------
  logic [`FPA_NUM_KEYS-1:0] key_press; // per-key press pulse
  logic any_press; // shared acknowledge pulse
  fpa_key_sync fpa_key_sync_inst (
    .clk(clk),
    .reset(reset),
    .keys_in(keys_in),
    .key_press(key_press),
    .any_press(any_press)
  );

  // ----------------------------------------
  // timebases
  // ----------------------------------------
  localparam logic [1:0] SCROLL_SEC = 2'(`FPA_SCROLL_SEC - 1);
  // wrap counter helper, used by every divider
  function automatic logic [24:0] wrap(input logic [24:0] c, input logic [24:0] lim);
    wrap = (c == lim - 25'd1) ? 25'd0 : c + 25'd1;
  endfunction : wrap

  logic [24:0] beep_cnt_reg, beep_cnt_next; // half of beep period
  logic [24:0] flash_cnt_reg, flash_cnt_next; // lamp and line flash
  logic [24:0] sec_cnt_reg, sec_cnt_next; // one second divider
  logic beep_ph_reg, beep_ph_next; // beep on/off phase
  logic flash_ph_reg, flash_ph_next; // flash phase
  logic sec_tick; // one-cycle second enable
  // divider next values
  always_comb begin
    beep_cnt_next = wrap(beep_cnt_reg, BEEP_HALF);
    flash_cnt_next = wrap(flash_cnt_reg, FLASH_HALF);
    sec_cnt_next = wrap(sec_cnt_reg, SEC_CYC);
    sec_tick = (sec_cnt_reg == SEC_CYC - 25'd1);
    // equal halves give one full beep per half second
    beep_ph_next = (beep_cnt_reg == BEEP_HALF - 25'd1) ? ~beep_ph_reg : beep_ph_reg;
    flash_ph_next = (flash_cnt_reg == FLASH_HALF - 25'd1) ? ~flash_ph_reg : flash_ph_reg;
  end
  // divider registers
  always_ff @(posedge clk) begin
    if (reset) begin
      beep_cnt_reg <= '0;
      flash_cnt_reg <= '0;
      sec_cnt_reg <= '0;
      beep_ph_reg <= 1'b0;
      flash_ph_reg <= 1'b0;
    end else begin
      beep_cnt_reg <= beep_cnt_next;
      flash_cnt_reg <= flash_cnt_next;
      sec_cnt_reg <= sec_cnt_next;
      beep_ph_reg <= beep_ph_next;
      flash_ph_reg <= flash_ph_next;
    end
  end

  // ----------------------------------------
  // alarm tracking and lamps
  // ----------------------------------------
  logic alarm_d_reg, alarm_d_next; // alarm level one cycle back
  logic unack_reg, unack_next; // new alarm not yet acknowledged
  logic hsil_reg, hsil_next; // horn silenced by operator
  fpa_pkg::fpa_lamps_t lamps_next;
  logic horn_next;
  logic new_alarm;
  // alarm state next values
  always_comb begin
    alarm_d_next = alarm_active;
    new_alarm = alarm_active & ~alarm_d_reg;
    // a fresh alarm wins over a press in the same cycle
    unack_next = new_alarm ? 1'b1 : (any_press ? 1'b0 : (unack_reg & alarm_active));
    hsil_next = new_alarm ? 1'b0 : (any_press ? 1'b1 : hsil_reg);
    lamps_next.online = (mode == fpa_pkg::MODE_ONLINE) ||
                        (mode == fpa_pkg::MODE_BATTERY);
    lamps_next.battery = (mode == fpa_pkg::MODE_BATTERY);
    lamps_next.bypass = (mode == fpa_pkg::MODE_BYPASS);
    // steady when acknowledged, flashing while unacknowledged
    lamps_next.alarm = alarm_active & (~unack_next | flash_ph_reg);
    horn_next = alarm_active & ~hsil_next & beep_ph_reg;
  end
  // alarm state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_d_reg <= 1'b0;
      unack_reg <= 1'b0;
      hsil_reg <= 1'b0;
      lamps <= '0;
      horn <= 1'b0;
    end else begin
      alarm_d_reg <= alarm_d_next;
      unack_reg <= unack_next;
      hsil_reg <= hsil_next;
      lamps <= lamps_next;
      horn <= horn_next;
    end
  end
  a_bypass_online: assert property (@(posedge clk) disable iff (reset)
    mode == fpa_pkg::MODE_BYPASS |=> !lamps.online && lamps.bypass)
    else $error("online lamp lit in bypass");
  a_battery_online: assert property (@(posedge clk) disable iff (reset)
    mode == fpa_pkg::MODE_BATTERY |=> lamps.online && lamps.battery)
    else $error("battery mode lamps wrong");
  a_off_dark: assert property (@(posedge clk) disable iff (reset)
    mode == fpa_pkg::MODE_OFF |=> !lamps.online) else $error("online lamp lit when off");
  a_horn_silence: assert property (@(posedge clk) disable iff (reset)
    (any_press && !new_alarm) ##1 !(alarm_active && !alarm_d_reg) |=> !horn)
    else $error("horn not silenced by press");
  a_no_alarm_dark: assert property (@(posedge clk) disable iff (reset)
    !alarm_active |=> !lamps.alarm && !horn) else $error("alarm outputs without alarm");
  a_ack_steady: assert property (@(posedge clk) disable iff (reset)
    alarm_active && !unack_next |=> lamps.alarm) else $error("acknowledged alarm not steady");

  // ----------------------------------------
  // display blanking and screens
  // ----------------------------------------
  logic [11:0] idle_sec_reg, idle_sec_next; // seconds since last press
  logic display_on_next;
  fpa_pkg::fpa_screen_t screen_next;
  fpa_pkg::fpa_label_t [`FPA_NUM_KEYS-1:0] labels_next;
  // screen next values
  always_comb begin
    idle_sec_next = idle_sec_reg;
    display_on_next = display_on;
    screen_next = screen;
    if (any_press) begin
      idle_sec_next = '0;
      display_on_next = 1'b1;
    end else if (sec_tick && idle_sec_reg != BLANK_SEC) begin
      idle_sec_next = idle_sec_reg + 12'd1;
    end
    if (!any_press && idle_sec_reg == BLANK_SEC) begin
      display_on_next = 1'b0;
    end
    // a press that only wakes or leaves splash does nothing else
    if (any_press && display_on) begin
      unique case (screen)
        fpa_pkg::SCR_SPLASH: screen_next = fpa_pkg::SCR_MIMIC;
        fpa_pkg::SCR_MIMIC: begin
          // operator picks the key under the title
          if (key_press[0]) screen_next = fpa_pkg::SCR_EVENTS;
          else if (key_press[1]) screen_next = fpa_pkg::SCR_METERS;
          else if (key_press[2]) screen_next = fpa_pkg::SCR_CONTROLS;
          else if (key_press[3]) screen_next = fpa_pkg::SCR_SETUP;
        end
        fpa_pkg::SCR_EVENTS, fpa_pkg::SCR_METERS, fpa_pkg::SCR_CONTROLS,
        fpa_pkg::SCR_SETUP: begin
          if (key_press[0]) screen_next = fpa_pkg::SCR_MIMIC;
        end
        default: screen_next = fpa_pkg::SCR_MIMIC; // illegal code
      endcase
    end
    // labels follow the screen now shown
    labels_next = '{default: fpa_pkg::LBL_NONE};
    unique case (screen_next)
      fpa_pkg::SCR_SPLASH: labels_next = '{default: fpa_pkg::LBL_NONE};
      fpa_pkg::SCR_MIMIC: begin
        labels_next[0] = fpa_pkg::LBL_EVENTS;
        labels_next[1] = fpa_pkg::LBL_METERS;
        labels_next[2] = fpa_pkg::LBL_CONTROLS;
        labels_next[3] = fpa_pkg::LBL_SETUP;
        labels_next[4] = fpa_pkg::LBL_LOADOFF;
      end
      default: labels_next[0] = fpa_pkg::LBL_HOME;
    endcase
  end
  // screen registers
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_sec_reg <= '0;
      display_on <= 1'b1;
      screen <= fpa_pkg::SCR_SPLASH;
      key_labels <= '{default: fpa_pkg::LBL_NONE};
    end else begin
      idle_sec_reg <= idle_sec_next;
      display_on <= display_on_next;
      screen <= screen_next;
      key_labels <= labels_next;
    end
  end
  a_splash_exit: assert property (@(posedge clk) disable iff (reset)
    screen == fpa_pkg::SCR_SPLASH && any_press && display_on |=> screen == fpa_pkg::SCR_MIMIC)
    else $error("splash not left on press");
  a_wake_press: assert property (@(posedge clk) disable iff (reset)
    any_press |=> display_on) else $error("display not restored by press");

  // ----------------------------------------
  // status line scroll and event messages
  // ----------------------------------------
  logic [1:0] scroll_reg, scroll_next; // seconds on current item
  fpa_pkg::fpa_item_t item_next;
  logic top_next;
  fpa_pkg::fpa_event_t msg_next;
  // status next values
  always_comb begin
    scroll_next = scroll_reg;
    item_next = status_item;
    if (sec_tick) begin
      scroll_next = (scroll_reg == SCROLL_SEC) ? 2'd0 : scroll_reg + 2'd1;
      if (scroll_reg == SCROLL_SEC) begin
        // probe items only appear when fitted
        if (status_item == fpa_pkg::ITM_RUNTIME && !probe_fitted) begin
          item_next = fpa_pkg::ITM_MODEL;
        end else if (status_item == fpa_pkg::ITM_HUMID) begin
          item_next = fpa_pkg::ITM_MODEL;
        end else begin
          item_next = fpa_pkg::fpa_item_t'(status_item + 3'd1);
        end
      end
    end
    top_next = ~((alarm_active | notice_attn) & flash_ph_reg);
    msg_next = event_in.valid ? event_in : status_msg;
  end
  // status registers
  always_ff @(posedge clk) begin
    if (reset) begin
      scroll_reg <= '0;
      status_item <= fpa_pkg::ITM_MODEL;
      top_line_on <= 1'b1;
      status_msg <= '0;
      active_log_wr <= 1'b0;
      history_log_wr <= 1'b0;
      log_code <= '0;
      log_cat <= fpa_pkg::CAT_ALARM;
      list_alarms <= 1'b0;
      list_notices <= 1'b0;
      list_commands <= 1'b0;
    end else begin
      scroll_reg <= scroll_next;
      status_item <= item_next;
      top_line_on <= top_next;
      status_msg <= msg_next;
      active_log_wr <= event_in.valid;
      history_log_wr <= event_in.valid & event_in.to_history;
      log_code <= event_in.code;
      log_cat <= event_in.cat;
      // status messages are not listed on the events screen
      list_alarms <= screen_next == fpa_pkg::SCR_EVENTS;
      list_notices <= screen_next == fpa_pkg::SCR_EVENTS;
      list_commands <= screen_next == fpa_pkg::SCR_EVENTS;
    end
  end
  a_log_write: assert property (@(posedge clk) disable iff (reset)
    event_in.valid |=> active_log_wr && log_code == $past(event_in.code))
    else $error("event not logged");
  a_probe_skip: assert property (@(posedge clk) disable iff (reset)
    !probe_fitted && status_item == fpa_pkg::ITM_RUNTIME |=> status_item != fpa_pkg::ITM_TEMP)
    else $error("probe item shown without probe");
endmodule : fpa_annunciator

// [test/fpa_operator.sv]
// operator model: presses and releases the front panel pushbuttons
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module fpa_operator (
  input wire logic clk,
  output logic [`FPA_NUM_KEYS-1:0] keys
);
  // --------------------------------
  // button state
  // --------------------------------
  // released buttons read low, as with a pull-down on each contact
  initial keys = '0;

  // one press under the wanted title, held long enough to pass the synchroniser
  task automatic press(input int k);
    @(posedge clk);
    #5 keys[k] = 1'b1;
    repeat (8) @(posedge clk);
    #5 keys[k] = 1'b0;
    // settle time so the next press is a separate release and press
    repeat (8) @(posedge clk);
  endtask : press
endmodule : fpa_operator

// [test/front_panel_annunciator_test.sv]
// self-checking bench for the front panel annunciator
`timescale 1ns/1ns
`include "fpa_cfg.svh"
module front_panel_annunciator_test;
  // --------------------------------
  // design signals
  // --------------------------------
  logic clk;
  logic reset;
  fpa_pkg::fpa_mode_t mode;
  logic alarm_active; // any alarm present
  logic notice_attn; // a notice needs attention
  logic probe_fitted; // environmental probe installed
  int n_h, n_a, n_t; // not-low counts of horn, alarm lamp, top line
  // shortened timebases so beep, flash, scroll and blanking fit in a short run
  localparam logic [24:0] BEEP_TB = 25'd20;
  localparam logic [24:0] FLASH_TB = 25'd30;
  localparam logic [24:0] SEC_TB = 25'd200;
  localparam logic [11:0] BLANK_TB = 12'd20;
  localparam int DWELL = `FPA_SCROLL_SEC * 200; // clocks per status item
  logic [`FPA_NUM_KEYS-1:0] keys; // driven by the operator model
  fpa_pkg::fpa_event_t event_in;
  fpa_pkg::fpa_lamps_t lamps;
  logic horn;
  logic display_on;
  fpa_pkg::fpa_screen_t screen;
  fpa_pkg::fpa_item_t status_item;
  logic top_line_on;
  fpa_pkg::fpa_event_t status_msg;
  logic active_log_wr;
  logic history_log_wr;
  logic [7:0] log_code;
  fpa_pkg::fpa_cat_t log_cat;
  logic list_alarms;
  logic list_notices;
  logic list_commands;
  fpa_pkg::fpa_label_t [`FPA_NUM_KEYS-1:0] key_labels;
  int err_count;
  int n_checks;

  fpa_annunciator #(.BEEP_HALF(BEEP_TB), .FLASH_HALF(FLASH_TB), .SEC_CYC(SEC_TB),
    .BLANK_SEC(BLANK_TB)) fpa_annunciator_inst (.clk(clk), .reset(reset), .mode(mode),
    .alarm_active(alarm_active), .notice_attn(notice_attn), .probe_fitted(probe_fitted),
    .keys_in(keys),
    .event_in(event_in), .lamps(lamps), .horn(horn), .display_on(display_on),
    .screen(screen), .status_item(status_item), .top_line_on(top_line_on),
    .status_msg(status_msg), .active_log_wr(active_log_wr), .history_log_wr(history_log_wr),
    .log_code(log_code), .log_cat(log_cat), .list_alarms(list_alarms),
    .list_notices(list_notices), .list_commands(list_commands), .key_labels(key_labels));

  fpa_operator fpa_operator_inst (.clk(clk), .keys(keys));

  // --------------------------------
  // clock, 50 ns period
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------------------
  // helpers
  // --------------------------------
  // compare on four-state values so an unknown never matches
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // single verdict point
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // one-cycle event, then look at the log outputs just after the edge that takes it
  task automatic send_event(input fpa_pkg::fpa_event_t ev);
    @(posedge clk);
    #5 event_in = ev;
    @(posedge clk);
    #5 event_in = '0;
    chk("active_log_wr", 16'h1, {15'h0, active_log_wr});
    chk("history_log_wr", {15'h0, ev.to_history}, {15'h0, history_log_wr});
    chk("log_code", {8'h0, ev.code}, {8'h0, log_code});
    chk("log_cat", {14'h0, ev.cat}, {14'h0, log_cat});
    chk("status_msg", {4'h0, ev}, {4'h0, status_msg});
  endtask : send_event

  // drive a mode and check the lamp pattern a few cycles later
  task automatic set_mode(input fpa_pkg::fpa_mode_t m, input logic [3:0] exp);
    @(posedge clk);
    #5 mode = m;
    repeat (3) @(posedge clk);
    #1 chk("lamps", {12'h0, exp}, {12'h0, lamps});
  endtask : set_mode

  // not-low cycles over whole beep and flash periods; half of them means equal halves
  task automatic measure(output int nh, output int na, output int nt);
    nh = 0;
    na = 0;
    nt = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      if (horn !== 1'b0) nh++;
      if (lamps.alarm !== 1'b0) na++;
      if (top_line_on !== 1'b0) nt++;
    end
  endtask : measure

  // bounded wait until a given status item is shown
  task automatic wait_item(input fpa_pkg::fpa_item_t want);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (status_item !== want && n < 4000);
    if (status_item !== want) begin
      $display("MISMATCH status_item expected %h seen %h", want, status_item);
      err_count++;
      stop_test();
    end
  endtask : wait_item

  // bounded wait for the item to move on, then check the new item and its dwell
  task automatic next_item(input fpa_pkg::fpa_item_t exp, input int dwell);
    fpa_pkg::fpa_item_t was;
    int n;
    was = status_item;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (status_item === was && n < 4000);
    if (status_item === was) begin
      $display("MISMATCH status_item expected %h seen %h", exp, status_item);
      err_count++;
      stop_test();
    end else begin
      chk("status_item", {13'h0, exp}, {13'h0, status_item});
      if (dwell != 0) begin
        chk("item_dwell", 16'(dwell), 16'(n));
      end
    end
  endtask : next_item

  // --------------------------------
  // watchdog: a hang ends in the same report
  // --------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    err_count = 0;
    n_checks = 0;
    reset = 1'b1;
    mode = fpa_pkg::MODE_OFF;
    alarm_active = 1'b0;
    notice_attn = 1'b0;
    probe_fitted = 1'b0;
    event_in = '0;
    repeat (16) @(posedge clk);
    #5 reset = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("screen", {13'h0, fpa_pkg::SCR_SPLASH}, {13'h0, screen});
    chk("display_on", 16'h1, {15'h0, display_on});
    chk("lamps", 16'h0, {12'h0, lamps});
    // key0 on the splash screen only leaves it, it must not open events
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    chk("label0", {13'h0, fpa_pkg::LBL_EVENTS}, {13'h0, key_labels[0]});
    chk("label1", {13'h0, fpa_pkg::LBL_METERS}, {13'h0, key_labels[1]});
    chk("label2", {13'h0, fpa_pkg::LBL_CONTROLS}, {13'h0, key_labels[2]});
    chk("label3", {13'h0, fpa_pkg::LBL_SETUP}, {13'h0, key_labels[3]});
    chk("label4", {13'h0, fpa_pkg::LBL_LOADOFF}, {13'h0, key_labels[4]});
    // lamp order is online, battery, bypass, alarm
    set_mode(fpa_pkg::MODE_ONLINE, 4'b1000);
    set_mode(fpa_pkg::MODE_BATTERY, 4'b1100);
    set_mode(fpa_pkg::MODE_BYPASS, 4'b0010);
    set_mode(fpa_pkg::MODE_OFF, 4'b0000);
    // every category, one idle cycle apart, with history on alternate ones
    for (int c = 0; c < 4; c++) begin
      send_event({1'b1, 2'(c), 8'(8'ha0 + c), 1'(c % 2)});
    end
    // alarm in online mode, then a press acknowledges and silences
    set_mode(fpa_pkg::MODE_ONLINE, 4'b1000);
    @(posedge clk);
    #5 alarm_active = 1'b1;
    repeat (2) @(posedge clk);
    // unacknowledged: horn beeps, red lamp and top line flash, each with equal halves
    measure(n_h, n_a, n_t);
    chk("horn_on", 16'd60, 16'(n_h));
    chk("alarm_flash", 16'd60, 16'(n_a));
    chk("top_blink", 16'd60, 16'(n_t));
    fpa_operator_inst.press(1);
    chk("screen", {13'h0, fpa_pkg::SCR_METERS}, {13'h0, screen});
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (i % 250 == 0) begin
        chk("horn", 16'h0, {15'h0, horn});
        chk("lamps", 16'h9, {12'h0, lamps});
      end
    end
    // key0 away from the mimic screen goes home
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_EVENTS}, {13'h0, screen});
    chk("lists", 16'h7, {13'h0, list_alarms, list_notices, list_commands});
    chk("label0", {13'h0, fpa_pkg::LBL_HOME}, {13'h0, key_labels[0]});
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    chk("list_alarms", 16'h0, {15'h0, list_alarms});
    // keys 2 and 3 open controls and setup, key0 goes home from each
    fpa_operator_inst.press(2);
    chk("screen", {13'h0, fpa_pkg::SCR_CONTROLS}, {13'h0, screen});
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    fpa_operator_inst.press(3);
    chk("screen", {13'h0, fpa_pkg::SCR_SETUP}, {13'h0, screen});
    chk("label0", {13'h0, fpa_pkg::LBL_HOME}, {13'h0, key_labels[0]});
    fpa_operator_inst.press(0);
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    // alarm clears: red lamp off, top line steady without attention
    @(posedge clk);
    #5 alarm_active = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("lamps", 16'h8, {12'h0, lamps});
    chk("top_line_on", 16'h1, {15'h0, top_line_on});
    chk("display_on", 16'h1, {15'h0, display_on});
    // a notice alone blinks the top line, horn and red lamp stay quiet
    @(posedge clk);
    #5 notice_attn = 1'b1;
    repeat (2) @(posedge clk);
    measure(n_h, n_a, n_t);
    chk("top_blink", 16'd60, 16'(n_t));
    chk("horn_off", 16'h0, 16'(n_h));
    chk("alarm_lamp", 16'h0, 16'(n_a));
    @(posedge clk);
    #5 notice_attn = 1'b0;
    // idle until the display darkens, bounded
    n_h = 0;
    do begin
      @(posedge clk);
      #1;
      n_h++;
    end while (display_on === 1'b1 && n_h < 5000);
    chk("display_on", 16'h0, {15'h0, display_on});
    if (display_on !== 1'b0) begin
      stop_test();
    end
    // a press while dark only wakes: key1 must not open meters
    fpa_operator_inst.press(1);
    chk("display_on", 16'h1, {15'h0, display_on});
    chk("screen", {13'h0, fpa_pkg::SCR_MIMIC}, {13'h0, screen});
    // status scroll without probe, then with probe fitted
    wait_item(fpa_pkg::ITM_RUNTIME);
    next_item(fpa_pkg::ITM_MODEL, 0);
    @(posedge clk);
    #5 probe_fitted = 1'b1;
    wait_item(fpa_pkg::ITM_RUNTIME);
    next_item(fpa_pkg::ITM_TEMP, 0);
    next_item(fpa_pkg::ITM_HUMID, DWELL);
    next_item(fpa_pkg::ITM_MODEL, DWELL);
    stop_test();
  end
endmodule : front_panel_annunciator_test
